// file: logic/ctpw_pkg.sv
// constants and types of the cascaded 16-bit timer block
// assumes: apb slave with byte offsets below, 32-bit data
`default_nettype none
package ctpw_pkg;
	localparam int CTPW_AW = 8;
	localparam int CTPW_CW = 16;
	localparam logic [7:0] CTPW_OFF_LCTL   = 8'h00;
	localparam logic [7:0] CTPW_OFF_UCTL   = 8'h04;
	localparam logic [7:0] CTPW_OFF_PER_LO = 8'h08;
	localparam logic [7:0] CTPW_OFF_PER_HI = 8'h0C;
	localparam logic [7:0] CTPW_OFF_WID_LO = 8'h10;
	localparam logic [7:0] CTPW_OFF_WID_HI = 8'h14;
	localparam logic [7:0] CTPW_OFF_STAT   = 8'h18;
	localparam logic [7:0] CTPW_RST_BYTE   = 8'h00;
	localparam int CTPW_INIT_BIT  = 7;
	localparam int CTPW_START_BIT = 3;
	localparam int CTPW_MODE_LSB  = 0;
	localparam int CTPW_CSEL_LSB  = 4;
	localparam int CTPW_STAT_FF   = 16;
	localparam int CTPW_STAT_RUN  = 17;
	localparam int CTPW_STAT_MODE = 20;
	localparam logic [2:0] CTPW_CSEL_EXT = 3'h7;
	localparam logic [7:0] CTPW_CODE_PPG  = 8'h57;
	localparam logic [7:0] CTPW_CODE_PPGS = 8'h5F;
	localparam logic [7:0] CTPW_CODE_WARM = 8'h05;
	typedef enum logic [2:0] {
		CTPW_MODE_TIMER  = 3'b100,
		CTPW_MODE_WARMUP = 3'b101,
		CTPW_MODE_PWM    = 3'b110,
		CTPW_MODE_PPG    = 3'b111
	} ctpw_mode_t;
endpackage
`default_nettype wire

// file: logic/ctpw_core_if.sv
// signals between register front end and counter core
// assumes: one clock domain, driven by ctpw_top
`timescale 1ns/100ps
`default_nettype none
interface ctpw_core_if;
	import ctpw_pkg::*;
	logic                tick;
	logic                run;
	logic                load;
	logic                ff_init;
	ctpw_mode_t          mode;
	logic [CTPW_CW-1:0]  period;
	logic [CTPW_CW-1:0]  width;
	logic [CTPW_CW-1:0]  count;
	logic                ff;
	logic                irq;
	modport ctrl (output tick, run, load, ff_init, mode, period, width, input count, ff, irq);
	modport core (input tick, run, load, ff_init, mode, period, width, output count, ff, irq);
endinterface
`default_nettype wire

// file: logic/ctpw_prescale.sv
// count tick source: power-of-two divider taps or external pin falls
// assumes: external pin is asynchronous to pclk
`timescale 1ns/100ps
`default_nettype none
module ctpw_prescale
	import ctpw_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [2:0] clk_sel,
	input  wire logic       ext_pin,
	output logic            tick
);
	typedef struct packed {
		logic [5:0] div;
		logic       s1;
		logic       s2;
		logic       s3;
	} ctpw_pre_t;
	ctpw_pre_t q;
	ctpw_pre_t d;
	logic [5:0] mask;

	always_comb begin
		d = q;
		d.div = q.div + 6'h01;
		d.s1 = ext_pin;
		d.s2 = q.s1;
		d.s3 = q.s2;
		mask = 6'((7'h01 << clk_sel) - 7'h01);
		if (clk_sel == CTPW_CSEL_EXT) begin
			tick = q.s3 & ~q.s2; // falling edge of pin
		end else begin
			tick = (q.div & mask) == mask; // internal tap
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	ext_edge_a: assert property ((clk_sel == CTPW_CSEL_EXT) && tick |-> $past(q.s2) && !q.s2)
		else $error("external tick without falling edge");
endmodule
`default_nettype wire

// file: logic/ctpw_core.sv
// 16-bit up-counter with width and period match, output flop
// assumes: control fields and tick come from ctpw_top
`timescale 1ns/100ps
`default_nettype none
module ctpw_core
	import ctpw_pkg::*;
(
	input  wire logic  pclk,
	input  wire logic  presetn,
	ctpw_core_if.core  cif
);
	typedef struct packed {
		logic [CTPW_CW-1:0] count;
		logic               ff;
		logic               irq;
	} ctpw_cnt_t;
	ctpw_cnt_t q;
	ctpw_cnt_t d;
	logic [CTPW_CW-1:0] warm_cmp;

	always_comb begin
		d = q;
		d.irq = 1'b0;
		warm_cmp = {cif.period[CTPW_CW-1:8], 8'h00};
		if (cif.load) begin
			d.ff = cif.ff_init;
			d.count = '0;
		end else if (cif.run && cif.tick) begin
			d.count = q.count + 16'h0001;
			unique case (cif.mode)
				CTPW_MODE_PPG: begin
					if (q.count == cif.period) begin
						d.ff = ~q.ff;
						d.count = '0;
						d.irq = 1'b1;
					end else if (q.count == cif.width) begin
						d.ff = ~q.ff;
					end
				end
				CTPW_MODE_WARMUP: begin
					if (q.count == warm_cmp) begin
						d.count = '0;
						d.irq = 1'b1;
					end
				end
				default: begin
					if (q.count == cif.period) begin
						d.count = '0;
						d.irq = 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign cif.count = q.count;
	assign cif.ff = q.ff;
	assign cif.irq = q.irq;
endmodule
`default_nettype wire

// file: logic/ctpw_top.sv
// apb front end of the cascaded 16-bit timer, pulse and warm-up modes
// assumes: apb master on pclk; count pin is asynchronous
// How it works
// - two bytes cascade into one 16-bit counter
// - width match inverts flop, counting continues
// - period match inverts flop, clears, interrupts
// - flop loads initial bit, reset clears
// - pulse pin is inverse of flop
// - new match values apply at once
// - stop holds pin; change level afterwards
// - start bit three runs the counter
// - clearing bit seven stopped drives pin high
// - 57h selects pulse mode, 5Fh starts
// - warm-up mode times oscillator start-up
// - 05h selects warm-up mode, flop zero
// - warm-up compares only period high byte
// - warm-up match interrupts and clears counter
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module ctpw_top
	import ctpw_pkg::*;
(
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [CTPW_AW-1:0]  paddr,
	input  wire logic [31:0]         pwdata,
	output logic [31:0]              prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                external_count_input_pin,
	output logic                     inverted_pulse_output_pin,
	output logic                     upper_timer_interrupt
);
	typedef struct packed {
		logic [7:0]  lower_timer_control;
		logic [7:0]  upper_timer_control;
		logic [7:0]  period_match_low_byte;
		logic [7:0]  period_match_high_byte;
		logic [7:0]  width_match_low_byte;
		logic [7:0]  width_match_high_byte;
		logic [31:0] rdata;
	} ctpw_regs_t;

	ctpw_regs_t  q;
	ctpw_regs_t  d;
	ctpw_core_if cif ();
	logic        setup;
	logic        access;
	logic        hit;
	logic        wr;
	logic        uctl_wr;
	logic        tick;
	logic [7:0]  wbyte;

	function automatic logic is_mapped(input logic [CTPW_AW-1:0] a);
		logic r;
		r = 1'b0;
		unique case (a)
			CTPW_OFF_LCTL, CTPW_OFF_UCTL, CTPW_OFF_PER_LO, CTPW_OFF_PER_HI,
			CTPW_OFF_WID_LO, CTPW_OFF_WID_HI, CTPW_OFF_STAT: r = 1'b1;
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	function automatic logic [31:0] rd_word(input ctpw_regs_t r, input logic [CTPW_AW-1:0] a,
		input logic [CTPW_CW-1:0] cnt, input logic ff);
		logic [31:0] w;
		w = 32'h0000_0000;
		unique case (a)
			CTPW_OFF_LCTL:   w[7:0] = r.lower_timer_control;
			CTPW_OFF_UCTL:   w[7:0] = r.upper_timer_control;
			CTPW_OFF_PER_LO: w[7:0] = r.period_match_low_byte;
			CTPW_OFF_PER_HI: w[7:0] = r.period_match_high_byte;
			CTPW_OFF_WID_LO: w[7:0] = r.width_match_low_byte;
			CTPW_OFF_WID_HI: w[7:0] = r.width_match_high_byte;
			CTPW_OFF_STAT: begin
				w[CTPW_CW-1:0] = cnt;
				w[CTPW_STAT_FF] = ff;
				w[CTPW_STAT_RUN] = r.upper_timer_control[CTPW_START_BIT];
				w[CTPW_STAT_MODE +: 3] = r.upper_timer_control[CTPW_MODE_LSB +: 3];
			end
			default: w = 32'h0000_0000;
		endcase
		return w;
	endfunction

	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign hit = is_mapped(paddr);
	assign wr = access & pwrite & hit;
	assign wbyte = pwdata[7:0];
	assign uctl_wr = wr && (paddr == CTPW_OFF_UCTL);

	// read data is captured in the setup cycle, so no wait state
	always_comb begin
		d = q;
		if (setup) begin
			d.rdata = rd_word(q, paddr, cif.count, cif.ff);
		end
		if (wr) begin
			unique case (paddr)
				CTPW_OFF_LCTL:   d.lower_timer_control = wbyte;
				CTPW_OFF_UCTL:   d.upper_timer_control = wbyte;
				CTPW_OFF_PER_LO: d.period_match_low_byte = wbyte;
				CTPW_OFF_PER_HI: d.period_match_high_byte = wbyte;
				CTPW_OFF_WID_LO: d.width_match_low_byte = wbyte;
				CTPW_OFF_WID_HI: d.width_match_high_byte = wbyte;
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '{lower_timer_control:    CTPW_RST_BYTE,
			       upper_timer_control:    CTPW_RST_BYTE,
			       period_match_low_byte:  CTPW_RST_BYTE,
			       period_match_high_byte: CTPW_RST_BYTE,
			       width_match_low_byte:   CTPW_RST_BYTE,
			       width_match_high_byte:  CTPW_RST_BYTE,
			       rdata:                  32'h0000_0000};
		end else begin
			q <= d;
		end
	end

	assign pready = 1'b1;
	assign pslverr = access & ~hit;
	assign prdata = q.rdata;

	ctpw_prescale u_pre (
		.pclk    (pclk),
		.presetn (presetn),
		.clk_sel (q.lower_timer_control[CTPW_CSEL_LSB +: 3]),
		.ext_pin (external_count_input_pin),
		.tick    (tick)
	);

	// the stopping write leaves the flop alone; the next upper control write loads it
	assign cif.load = uctl_wr && !q.upper_timer_control[CTPW_START_BIT];
	assign cif.ff_init = wbyte[CTPW_INIT_BIT];
	assign cif.tick = tick;
	assign cif.run = q.upper_timer_control[CTPW_START_BIT];
	assign cif.mode = ctpw_mode_t'(q.upper_timer_control[CTPW_MODE_LSB +: 3]);
	assign cif.period = {q.period_match_high_byte, q.period_match_low_byte};
	assign cif.width = {q.width_match_high_byte, q.width_match_low_byte};

	ctpw_core u_core (
		.pclk    (pclk),
		.presetn (presetn),
		.cif     (cif.core)
	);

	assign inverted_pulse_output_pin = ~cif.ff;
	assign upper_timer_interrupt = cif.irq;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic [CTPW_CW-1:0] warm_cmp_a;
	assign warm_cmp_a = {cif.period[CTPW_CW-1:8], 8'h00};

	sequence s_ppg_wrap;
		cif.run && cif.tick && !cif.load && cif.mode == CTPW_MODE_PPG && cif.count == cif.period;
	endsequence

	sequence s_restart;
		cif.run && cif.tick && !cif.load && cif.count == 16'h0000;
	endsequence

	width_toggle_a: assert property (cif.run && cif.tick && !cif.load && cif.mode == CTPW_MODE_PPG
		&& cif.count == cif.width && cif.count != cif.period
		|=> cif.ff != $past(cif.ff) && cif.count == $past(cif.count) + 16'h0001)
		else $error("width match did not invert flop and keep counting");

	period_wrap_a: assert property (s_ppg_wrap |=> upper_timer_interrupt && cif.count == 16'h0000
		&& inverted_pulse_output_pin != $past(inverted_pulse_output_pin))
		else $error("period match did not clear, toggle and interrupt");

	restart_zero_a: assert property (s_ppg_wrap ##1 s_restart |=> cif.count == 16'h0001)
		else $error("counter did not restart after period clear");

	init_load_a: assert property (uctl_wr && !cif.run |=> cif.ff == $past(pwdata[CTPW_INIT_BIT]))
		else $error("flop not loaded from initial bit");

	stop_hold_a: assert property (uctl_wr && cif.run && !pwdata[CTPW_START_BIT]
		|=> !cif.run && $stable(inverted_pulse_output_pin) ##1 $stable(inverted_pulse_output_pin))
		else $error("pin changed on stopping write");

	pin_high_a: assert property (uctl_wr && !cif.run && !pwdata[CTPW_INIT_BIT] && !pwdata[CTPW_START_BIT]
		|=> inverted_pulse_output_pin)
		else $error("cleared initial bit did not drive pin high");

	stopped_hold_a: assert property (!cif.run && !cif.load |=> $stable(cif.count) && $stable(cif.ff))
		else $error("counter moved while stopped");

	ppg_start_a: assert property (uctl_wr && pwdata[7:0] == CTPW_CODE_PPGS && !cif.run
		|=> cif.run && cif.mode == CTPW_MODE_PPG && !cif.ff)
		else $error("5Fh did not start pulse mode");

	warm_sel_a: assert property (uctl_wr && pwdata[7:0] == CTPW_CODE_WARM
		|=> !cif.run && cif.mode == CTPW_MODE_WARMUP && (!$past(cif.run) -> !cif.ff))
		else $error("05h did not select warm-up mode");

	warm_match_a: assert property (cif.run && cif.tick && !cif.load && cif.mode == CTPW_MODE_WARMUP
		&& cif.count == warm_cmp_a |=> upper_timer_interrupt && cif.count == 16'h0000)
		else $error("warm-up match did not clear and interrupt");

	warm_ffhold_a: assert property (cif.mode == CTPW_MODE_WARMUP && !cif.load |=> $stable(cif.ff))
		else $error("flop toggled in warm-up mode");

	count_step_a: assert property (cif.run && cif.tick && !cif.load && !upper_timer_interrupt ##1 !upper_timer_interrupt
		|-> cif.count == $past(cif.count) + 16'h0001)
		else $error("counter did not step on tick");

	bad_addr_a: assert property (access && !hit |-> pslverr && pready ##1 $stable(q.upper_timer_control))
		else $error("unmapped access not refused");
endmodule
`default_nettype wire

// file: testbench/ctpw_top_tb.sv
// self-checking bench of the cascaded timer: pulse, stop, external count, warm-up
// assumes: ctpw_top with zero-wait apb slave, one 25 MHz clock
`timescale 1ns/100ps
`default_nettype none
module ctpw_top_tb;
	import ctpw_pkg::*;
	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        ext     = 1'b1;
	logic        pin;
	logic        irq;
	logic [31:0] rd;
	logic        er;
	int          bad_count = 0;
	int          cmp_count = 0;
	int          cyc       = 0;
	int          n;

	always #20 pclk = ~pclk;

	ctpw_top i_ctpw_top (
		.pclk                      (pclk),
		.presetn                   (presetn),
		.psel                      (psel),
		.penable                   (penable),
		.pwrite                    (pwrite),
		.paddr                     (paddr),
		.pwdata                    (pwdata),
		.prdata                    (prdata),
		.pready                    (pready),
		.pslverr                   (pslverr),
		.external_count_input_pin  (ext),
		.inverted_pulse_output_pin (pin),
		.upper_timer_interrupt     (irq)
	);

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one apb transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 100);
		rd = prdata;
		er = pslverr;
		if (k >= 100)
			chk("pready", 32'h1, {31'h0, pready});
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask

	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask

	// cycles until the interrupt pulse, sampled on falling edges
	task automatic wirq(output int m);
		m = 0;
		do begin
			@(negedge pclk);
			m++;
		end while (irq !== 1'b1 && m < 2000);
	endtask

	// levels kept four cycles each
	task automatic ext_fall;
		@(posedge pclk);
		ext <= 1'b0;
		repeat (4) @(posedge pclk);
		ext <= 1'b1;
		repeat (4) @(posedge pclk);
	endtask

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			bad_count++;
			complete_run();
		end
	end

	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		chk("reset pin", 32'h1, {31'h0, pin});
		chk("reset irq", 32'h0, {31'h0, irq});
		for (int a = 0; a <= 24; a += 4) begin
			rdc("reset reg", a[7:0], 32'h0);
		end
		apb(1'b0, 8'h1C, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, er});
		chk("unmapped data", 32'h0, rd);
		// pulse mode, tick every clock, period 5, width 1
		wr(CTPW_OFF_LCTL, 8'h00);
		wr(CTPW_OFF_PER_LO, 8'h05);
		wr(CTPW_OFF_PER_HI, 8'h00);
		wr(CTPW_OFF_WID_LO, 8'h01);
		wr(CTPW_OFF_WID_HI, 8'h00);
		wr(CTPW_OFF_UCTL, CTPW_CODE_PPG);
		@(negedge pclk);
		chk("ppg pin", 32'h1, {31'h0, pin});
		rdc("ppg status", CTPW_OFF_STAT, 32'h0070_0000);
		wr(CTPW_OFF_UCTL, CTPW_CODE_PPGS);
		wirq(n);
		wirq(n);
		chk("ppg period", 32'd6, n);
		for (int k = 1; k <= 6; k++) begin
			@(negedge pclk);
			chk("ppg wave", {31'h0, k == 1 || k == 6}, {31'h0, pin});
			chk("ppg irq", {31'h0, k == 6}, {31'h0, irq});
		end
		wr(CTPW_OFF_PER_LO, 8'h09);
		wirq(n);
		wirq(n);
		chk("new period", 32'd10, n);
		// external count source, three falls
		wr(CTPW_OFF_UCTL, CTPW_CODE_PPG);
		wr(CTPW_OFF_LCTL, {1'b0, CTPW_CSEL_EXT, 4'h0});
		wr(CTPW_OFF_PER_LO, 8'h10);
		wr(CTPW_OFF_UCTL, CTPW_CODE_PPG);
		wr(CTPW_OFF_UCTL, CTPW_CODE_PPGS);
		repeat (3) ext_fall();
		repeat (6) @(posedge pclk);
		rdc("ext count", CTPW_OFF_STAT, 32'h0073_0003);
		wr(CTPW_OFF_UCTL, CTPW_CODE_PPG);
		ext_fall();
		repeat (6) @(posedge pclk);
		rdc("stopped", CTPW_OFF_STAT, 32'h0071_0003);
		chk("held pin", 32'h0, {31'h0, pin});
		wr(CTPW_OFF_UCTL, 8'hD7);
		@(negedge pclk);
		chk("init one", 32'h0, {31'h0, pin});
		wr(CTPW_OFF_UCTL, CTPW_CODE_PPG);
		@(negedge pclk);
		chk("init zero", 32'h1, {31'h0, pin});
		// warm-up, low byte of period ignored
		wr(CTPW_OFF_LCTL, 8'h00);
		wr(CTPW_OFF_PER_LO, 8'h34);
		wr(CTPW_OFF_PER_HI, 8'h01);
		wr(CTPW_OFF_UCTL, CTPW_CODE_WARM);
		rdc("warm status", CTPW_OFF_STAT, 32'h0050_0000);
		wr(CTPW_OFF_UCTL, 8'h0D);
		wirq(n);
		wirq(n);
		chk("warm period", 32'd257, n);
		chk("warm pin", 32'h1, {31'h0, pin});
		wr(CTPW_OFF_UCTL, CTPW_CODE_WARM);
		complete_run();
	end
endmodule
`default_nettype wire
